/* rtl/pdm_map.svh */
// register map, field positions and reset values of the power-down controller
// Function
// - halt with deep-mode select 0 enters sleep mode.
// - halt with deep-mode select 1 enters standby, stopping clock, CPU, peripherals.
// - sleep halts CPU at once, keeps registers, peripherals keep running.
// - standby control register is 8-bit read/write, resets to 0x1f.
// - deep-mode select at bit 7, cannot be set while watchdog runs.
// - port-float select at bit 6, cannot be set while watchdog runs.
// - standby keeps port states if port-float is 0, else high impedance.
// - bit 5 reads 0, read-only; software writes only 0 there.
// - writes to bits 4..0 ignored, they always read 1.
// - accepted interrupt ends sleep; priority at or below mask does not wake.
// - interrupt disabled by its peripheral does not end sleep.
// - DMA address error during sleep ends sleep with exception processing.
// - reset low with nonmaskable pin high: leave sleep, power-on reset.
// - reset low with nonmaskable pin low: leave sleep, manual reset.
// - rising edge selected: nonmaskable pin rising in sleep wakes.
// - falling edge selected: nonmaskable pin falling in sleep wakes.
// - standby ends only on nonmaskable interrupt, power-on or manual reset.
`ifndef PDM_MAP_SVH
`define PDM_MAP_SVH
`define PDM_ADDR_W 28
`define PDM_STBY_CTRL_ADDR 28'h5ffffbc
`define PDM_STBY_CTRL_RST 8'h1f
`define PDM_DEEP_BIT 7
`define PDM_FLOAT_BIT 6
`define PDM_ZERO_BIT 5
`define PDM_ONES_MASK 8'h1f
`define PDM_LVL_W 4
`endif

/* rtl/pdm_pkg.sv */
// types of the power-down controller
package pdm_pkg;
  typedef enum logic [2:0] {
    PDM_RUN = 3'b001,
    PDM_SLEEP = 3'b010,
    PDM_STBY = 3'b100
  } pdm_state_t;
  typedef enum logic [1:0] {
    PDM_RST_NONE = 2'h0,
    PDM_RST_POWER_ON = 2'h1,
    PDM_RST_MANUAL = 2'h2
  } pdm_rst_kind_t;
endpackage

/* rtl/pdm_wake_if.sv */
// wake request bundle between the wake qualifier and the mode controller
`timescale 1ns/1ps
interface pdm_wake_if;
  logic int_wake;
  logic nmi_wake;
  logic dma_wake;
  logic por_req;
  logic man_req;
  modport src (output int_wake, output nmi_wake, output dma_wake, output por_req, output man_req);
  modport dst (input int_wake, input nmi_wake, input dma_wake, input por_req, input man_req);
endinterface

/* rtl/pdm_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pdm_sync (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic rst_val_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_ff;
  logic hold_ff;

  // first stage read only by the second; both preset high (idle pin level)
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= 1'b1;
      hold_ff <= 1'b1;
    end else begin
      meta_ff <= d_i;
      hold_ff <= meta_ff;
    end
  end
  assign q_o = hold_ff;
endmodule

/* rtl/pdm_wake_qual.sv */
// qualifies interrupt, dma error, nonmaskable edge and reset pin into wake requests
`timescale 1ns/1ps
`include "pdm_map.svh"
module pdm_wake_qual (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic irq_req_i,
  input wire logic irq_src_en_i,
  input wire logic [`PDM_LVL_W-1:0] irq_level_i,
  input wire logic [`PDM_LVL_W-1:0] mask_level_i,
  input wire logic dma_addr_err_i,
  input wire logic nmi_s_i,
  input wire logic init_s_i,
  input wire logic nmi_rise_sel_i,
  pdm_wake_if.src wk
);
  logic nmi_prev_ff;
  logic init_prev_ff;

  // edge history of already synchronised pins
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nmi_prev_ff <= 1'b1;
      init_prev_ff <= 1'b1;
    end else begin
      nmi_prev_ff <= nmi_s_i;
      init_prev_ff <= init_s_i;
    end
  end

  wire nmi_rise = nmi_s_i & ~nmi_prev_ff;
  wire nmi_fall = ~nmi_s_i & nmi_prev_ff;
  wire init_fall = ~init_s_i & init_prev_ff;

  // priority must strictly exceed the mask; disabled sources never wake
  assign wk.int_wake = irq_req_i & irq_src_en_i & (irq_level_i > mask_level_i);
  assign wk.dma_wake = dma_addr_err_i;
  assign wk.nmi_wake = nmi_rise_sel_i ? nmi_rise : nmi_fall;
  // reset kind follows the nonmaskable pin level at the reset pin's fall
  assign wk.por_req = init_fall & nmi_s_i;
  assign wk.man_req = init_fall & ~nmi_s_i;
endmodule

/* rtl/pdm_top.sv */
// power-down mode controller: standby control register, sleep/standby state and wake
`timescale 1ns/1ps
`include "pdm_map.svh"
module pdm_top (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [`PDM_ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic halt_exec_i,
  input wire logic watchdog_run_enable_i,
  input wire logic nonmaskable_edge_select_i,
  input wire logic irq_req_i,
  input wire logic irq_src_en_i,
  input wire logic [`PDM_LVL_W-1:0] irq_level_i,
  input wire logic [`PDM_LVL_W-1:0] mask_level_i,
  input wire logic dma_addr_err_i,
  input wire logic nmi_pin_i,
  input wire logic chip_init_pin_n_i,
  output logic cpu_halt_o,
  output logic clk_stop_o,
  output logic periph_stop_o,
  output logic port_float_o,
  output logic wake_o,
  output logic [1:0] wake_cause_o,
  output logic [1:0] rst_kind_o
);
  logic rst_meta_ff;
  logic rst_n_ff;
  logic nmi_s;
  logic init_s;
  logic [7:0] rdata_ff;
  logic deep_ff;
  logic float_ff;
  logic wake_ff;
  logic [1:0] cause_ff;
  logic [1:0] rkind_ff;
  pdm_pkg::pdm_state_t state_ff;
  pdm_pkg::pdm_state_t nxt_state;
  pdm_wake_if wk ();

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // pins come from outside the clock domain
  pdm_sync u_nmi_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_ff),
    .rst_val_i(1'b1),
    .d_i(nmi_pin_i),
    .q_o(nmi_s)
  );
  pdm_sync u_init_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_ff),
    .rst_val_i(1'b1),
    .d_i(chip_init_pin_n_i),
    .q_o(init_s)
  );

  pdm_wake_qual u_qual (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_ff),
    .irq_req_i(irq_req_i),
    .irq_src_en_i(irq_src_en_i),
    .irq_level_i(irq_level_i),
    .mask_level_i(mask_level_i),
    .dma_addr_err_i(dma_addr_err_i),
    .nmi_s_i(nmi_s),
    .init_s_i(init_s),
    .nmi_rise_sel_i(nonmaskable_edge_select_i),
    .wk(wk)
  );

  // register decode
  wire sel = (addr_i == `PDM_STBY_CTRL_ADDR);
  wire wr_hit = wr_i & sel;
  wire rd_hit = rd_i & sel;
  // a 1 is refused while the watchdog runs; a 0 is always accepted
  wire nxt_deep = wdata_i[`PDM_DEEP_BIT] & ~watchdog_run_enable_i;
  wire nxt_float = wdata_i[`PDM_FLOAT_BIT] & ~watchdog_run_enable_i;
  // bit 5 fixed 0, bits 4..0 fixed 1, no storage behind them
  // the ones mask is a full byte; only its low five bits form the fixed field
  wire [7:0] ones_view = `PDM_ONES_MASK;
  wire [7:0] reg_view = {deep_ff, float_ff, 1'b0, ones_view[4:0]};

  // writable fields only; reset gives 0x1f image
  always_ff @(posedge mclk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      deep_ff <= 1'b0;
      float_ff <= 1'b0;
    end else if (wr_hit) begin
      deep_ff <= nxt_deep;
      float_ff <= nxt_float;
    end
  end

  // read data stands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge mclk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= rd_hit ? reg_view : 8'h00;
    end
  end
  assign rdata_o = rdata_ff;

  wire sleep_wake = wk.int_wake | wk.dma_wake | wk.nmi_wake | wk.por_req | wk.man_req;
  // only nmi and resets leave standby; the clock is modelled as gated outside
  wire stby_wake = wk.nmi_wake | wk.por_req | wk.man_req;
  wire any_wake = (state_ff == pdm_pkg::PDM_SLEEP) ? sleep_wake :
                  (state_ff == pdm_pkg::PDM_STBY) ? stby_wake : 1'b0;

  // mode selection on halt, exit on qualified wake
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      pdm_pkg::PDM_RUN: begin
        if (halt_exec_i) begin
          nxt_state = deep_ff ? pdm_pkg::PDM_STBY : pdm_pkg::PDM_SLEEP;
        end
      end
      pdm_pkg::PDM_SLEEP: begin
        if (sleep_wake) begin
          nxt_state = pdm_pkg::PDM_RUN;
        end
      end
      pdm_pkg::PDM_STBY: begin
        if (stby_wake) begin
          nxt_state = pdm_pkg::PDM_RUN;
        end
      end
      default: nxt_state = pdm_pkg::PDM_RUN;
    endcase
  end

  // reset kinds take precedence over wake cause reporting
  wire [1:0] nxt_cause = (wk.por_req | wk.man_req) ? 2'h3 :
                         wk.nmi_wake ? 2'h2 : wk.dma_wake ? 2'h1 : 2'h0;
  wire [1:0] nxt_rkind = wk.por_req ? pdm_pkg::PDM_RST_POWER_ON :
                         wk.man_req ? pdm_pkg::PDM_RST_MANUAL : pdm_pkg::PDM_RST_NONE;

  // state and one-cycle wake pulse with its cause
  always_ff @(posedge mclk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= pdm_pkg::PDM_RUN;
      wake_ff <= 1'b0;
      cause_ff <= 2'h0;
      rkind_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      wake_ff <= any_wake;
      cause_ff <= any_wake ? nxt_cause : cause_ff;
      rkind_ff <= any_wake ? nxt_rkind : 2'h0;
    end
  end

  // cpu halts in both modes, clock and peripherals stop only in standby
  assign cpu_halt_o = (state_ff != pdm_pkg::PDM_RUN);
  assign clk_stop_o = (state_ff == pdm_pkg::PDM_STBY);
  assign periph_stop_o = (state_ff == pdm_pkg::PDM_STBY);
  assign port_float_o = (state_ff == pdm_pkg::PDM_STBY) & float_ff;
  assign wake_o = wake_ff;
  assign wake_cause_o = cause_ff;
  assign rst_kind_o = rkind_ff;

  // halt taken in run, split by the deep-mode select bit
  sequence s_sleep_halt;
    (state_ff == pdm_pkg::PDM_RUN) && halt_exec_i && !deep_ff;
  endsequence
  sequence s_stby_halt;
    (state_ff == pdm_pkg::PDM_RUN) && halt_exec_i && deep_ff;
  endsequence
  // wake pulse with the cpu already released
  sequence s_woken;
    wake_o && !cpu_halt_o;
  endsequence

  // a 1 written while the watchdog runs must not stick
  AST_DEEP_REFUSED: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    wr_hit && watchdog_run_enable_i |=> !deep_ff)
    else $error("deep select set while watchdog runs");

  AST_FLOAT_REFUSED: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    wr_hit && watchdog_run_enable_i |=> !float_ff)
    else $error("float select set while watchdog runs");

  // with the watchdog stopped the written value is taken as is
  AST_DEEP_TAKEN: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    wr_hit && !watchdog_run_enable_i |=> deep_ff == $past(wdata_i[`PDM_DEEP_BIT]))
    else $error("deep select write lost");

  AST_FLOAT_TAKEN: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    wr_hit && !watchdog_run_enable_i |=> float_ff == $past(wdata_i[`PDM_FLOAT_BIT]))
    else $error("float select write lost");

  // fields only move on a write hit
  AST_DEEP_KEPT: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    !wr_hit |=> $stable(deep_ff))
    else $error("deep select changed without write");

  AST_FLOAT_KEPT: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    !wr_hit |=> $stable(float_ff))
    else $error("float select changed without write");

  // fixed bits never depend on what was written
  AST_READ_FIXED: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    rd_hit |=> (rdata_o[5:0] == 6'h1f))
    else $error("fixed bits read wrong");

  AST_READ_ZERO_BIT: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    rd_hit |=> !rdata_o[`PDM_ZERO_BIT])
    else $error("reserved zero bit read as one");

  AST_READ_FIELDS: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    rd_hit |=> rdata_o[7:6] == $past({deep_ff, float_ff}))
    else $error("writable fields read wrong");

  // read data stands one cycle only, zero otherwise
  AST_READ_IDLE: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    !rd_hit |=> rdata_o == 8'h00)
    else $error("read data outside its cycle");

  AST_SLEEP_ENTRY: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    s_sleep_halt |=> cpu_halt_o && !clk_stop_o)
    else $error("sleep not entered");

  AST_STBY_ENTRY: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    s_stby_halt |=> clk_stop_o && periph_stop_o)
    else $error("standby not entered");

  // sleep halts only the cpu; peripherals and clock keep running
  AST_SLEEP_OUTS: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    (state_ff == pdm_pkg::PDM_SLEEP) |-> cpu_halt_o && !clk_stop_o && !periph_stop_o)
    else $error("sleep outputs wrong");

  AST_STBY_OUTS: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    (state_ff == pdm_pkg::PDM_STBY) |-> cpu_halt_o && clk_stop_o && periph_stop_o)
    else $error("standby outputs wrong");

  AST_RUN_OUTS: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    (state_ff == pdm_pkg::PDM_RUN) |-> !cpu_halt_o && !clk_stop_o && !periph_stop_o)
    else $error("run outputs wrong");

  AST_FLOAT_PORTS: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    port_float_o |-> clk_stop_o && float_ff)
    else $error("ports floated outside standby");

  // in standby the port state follows the float bit both ways
  AST_FLOAT_FOLLOWS: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    (state_ff == pdm_pkg::PDM_STBY) |-> port_float_o == float_ff)
    else $error("port float does not follow its bit");

  AST_STBY_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    (state_ff == pdm_pkg::PDM_STBY) && !stby_wake |=> clk_stop_o)
    else $error("standby left without nmi or reset");

  AST_STBY_WAKE: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    (state_ff == pdm_pkg::PDM_STBY) && stby_wake |=> s_woken)
    else $error("standby not left on nmi or reset");

  AST_SLEEP_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    (state_ff == pdm_pkg::PDM_SLEEP) && !sleep_wake |=> cpu_halt_o && !wake_o)
    else $error("sleep left without a wake source");

  AST_WAKE_PULSE: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    (state_ff == pdm_pkg::PDM_SLEEP) && sleep_wake |=> s_woken)
    else $error("wake not given next cycle");

  // the pulse is one cycle and never comes from run
  AST_WAKE_ONE: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    wake_o |=> !wake_o)
    else $error("wake pulse too long");

  AST_NO_WAKE_RUN: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    (state_ff == pdm_pkg::PDM_RUN) |=> !wake_o)
    else $error("wake given while running");

  AST_MASKED_IRQ: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    (irq_level_i <= mask_level_i) || !irq_src_en_i |-> !wk.int_wake)
    else $error("masked interrupt woke cpu");

  // a lone accepted interrupt reports cause zero
  AST_IRQ_WAKE: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    (state_ff == pdm_pkg::PDM_SLEEP) && wk.int_wake && !wk.dma_wake && !wk.nmi_wake &&
    !wk.por_req && !wk.man_req |=> wake_o && wake_cause_o == 2'h0)
    else $error("interrupt wake cause wrong");

  // address error wakes sleep with cause one unless a higher cause shares the cycle
  AST_DMA_WAKE: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    (state_ff == pdm_pkg::PDM_SLEEP) && wk.dma_wake && !wk.nmi_wake &&
    !wk.por_req && !wk.man_req |=> wake_o && wake_cause_o == 2'h1)
    else $error("dma error wake wrong");

  AST_POR_KIND: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    any_wake && wk.por_req |=> rst_kind_o == 2'h1 && wake_cause_o == 2'h3)
    else $error("power-on reset kind wrong");

  AST_MAN_KIND: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    any_wake && wk.man_req |=> rst_kind_o == 2'h2 && wake_cause_o == 2'h3)
    else $error("manual reset kind wrong");

  // reset kind is a pulse beside the wake pulse only
  AST_KIND_PULSE: assert property (@(posedge mclk_i) disable iff (!rst_n_ff)
    !wake_o |-> rst_kind_o == 2'h0)
    else $error("reset kind outside wake pulse");
endmodule

/* verification/pdm_far_model.sv */
// far-side model: cpu halt pulse, interrupt source, dma engine, watchdog and pins
`timescale 1ns/1ps
module pdm_far_model (
  input wire logic mclk_i,
  output logic halt_o,
  output logic wd_run_o,
  output logic edge_sel_o,
  output logic irq_req_o,
  output logic irq_en_o,
  output logic [3:0] irq_lvl_o,
  output logic [3:0] mask_lvl_o,
  output logic dma_err_o,
  output logic nmi_o,
  output logic init_n_o
);
  // pins idle high so the synchronisers see no edge at reset release
  initial begin
    {halt_o, wd_run_o, edge_sel_o, irq_req_o, irq_en_o, dma_err_o} = 6'h08;
    {irq_lvl_o, mask_lvl_o} = 8'h00;
    {nmi_o, init_n_o} = 2'h3;
  end
  // halt is a single-cycle pulse, as the cpu issues it once per instruction
  task automatic halt();
    @(posedge mclk_i);
    halt_o <= 1'b1;
    @(posedge mclk_i);
    halt_o <= 1'b0;
  endtask
  // address error shows for one cycle only
  task automatic dma();
    @(posedge mclk_i);
    dma_err_o <= 1'b1;
    @(posedge mclk_i);
    dma_err_o <= 1'b0;
  endtask
  // interrupt request with its enable, priority and the cpu mask
  task automatic irq(input logic r, input logic e, input logic [3:0] l, input logic [3:0] m);
    @(posedge mclk_i);
    irq_req_o <= r;
    irq_en_o <= e;
    irq_lvl_o <= l;
    mask_lvl_o <= m;
  endtask
  // asynchronous pins, changed on a clock edge for repeatable runs
  task automatic pins(input logic n, input logic i);
    @(posedge mclk_i);
    nmi_o <= n;
    init_n_o <= i;
  endtask
  // watchdog run level and nonmaskable edge choice
  task automatic cfg(input logic w, input logic s);
    @(posedge mclk_i);
    wd_run_o <= w;
    edge_sel_o <= s;
  endtask
endmodule

/* verification/testbench.sv */
// register, sleep, standby and wake tests of the power-down controller
`timescale 1ns/1ps
`include "pdm_map.svh"
module testbench;
  logic mclk_i, nrst_i, wr_i, rd_i, hlt, wdr, esel, irq, ien, dmae, nmi, initn;
  logic [`PDM_ADDR_W-1:0] addr_i;
  logic [7:0] wdata_i, rdata_o;
  logic [3:0] lvl, msk;
  logic cpu_halt_o, clk_stop_o, periph_stop_o, port_float_o, wake_o;
  logic [1:0] wake_cause_o, rst_kind_o;
  int fail_count = 0;
  int comparisons = 0;
  pdm_far_model pdm_far_model_inst (.mclk_i(mclk_i), .halt_o(hlt), .wd_run_o(wdr),
    .edge_sel_o(esel), .irq_req_o(irq), .irq_en_o(ien), .irq_lvl_o(lvl), .mask_lvl_o(msk),
    .dma_err_o(dmae), .nmi_o(nmi), .init_n_o(initn));
  pdm_top pdm_top_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .halt_exec_i(hlt),
    .watchdog_run_enable_i(wdr), .nonmaskable_edge_select_i(esel), .irq_req_i(irq),
    .irq_src_en_i(ien), .irq_level_i(lvl), .mask_level_i(msk), .dma_addr_err_i(dmae),
    .nmi_pin_i(nmi), .chip_init_pin_n_i(initn), .cpu_halt_o(cpu_halt_o),
    .clk_stop_o(clk_stop_o), .periph_stop_o(periph_stop_o), .port_float_o(port_float_o),
    .wake_o(wake_o), .wake_cause_o(wake_cause_o), .rst_kind_o(rst_kind_o));
  // 50 MHz system clock
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [27:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [27:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    check("rdata", exp, rdata_o);
  endtask
  // halt, clock stop, peripheral stop and port float as one nibble
  task automatic modes(input logic [7:0] exp);
    @(negedge mclk_i);
    check("modes", exp, {4'h0, cpu_halt_o, clk_stop_o, periph_stop_o, port_float_o});
  endtask
  // bounded wait: a missing wake is reported, not hung on
  task automatic wait_wake(input logic [1:0] cause, input logic [1:0] kind);
    int n;
    n = 0;
    while (wake_o !== 1'b1 && n < 20) begin
      @(negedge mclk_i);
      n++;
    end
    check("wake", 8'h01, {7'h0, wake_o});
    check("cause", {6'h0, cause}, {6'h0, wake_cause_o});
    check("reset kind", {6'h0, kind}, {6'h0, rst_kind_o});
    check("halt after wake", 8'h00, {7'h0, cpu_halt_o});
    @(negedge mclk_i);
    check("wake width", 8'h00, {7'h0, wake_o});
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // the whole run is under two hundred cycles
  initial begin
    #100000;
    fail_count++;
    final_report();
  end
  initial begin
    {nrst_i, wr_i, rd_i, wdata_i, addr_i} = '0;
    repeat (20) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (5) @(posedge mclk_i);
    reg_rd(`PDM_STBY_CTRL_ADDR, 8'h1f);
    pdm_far_model_inst.cfg(1'b1, 1'b1);
    reg_wr(`PDM_STBY_CTRL_ADDR, 8'hdf);
    reg_rd(`PDM_STBY_CTRL_ADDR, 8'h1f);
    pdm_far_model_inst.cfg(1'b0, 1'b1);
    reg_wr(`PDM_STBY_CTRL_ADDR, 8'hc0);
    reg_rd(`PDM_STBY_CTRL_ADDR, 8'hdf);
    reg_rd(28'h5ffffb8, 8'h00);
    $display("test registers done");
    pdm_far_model_inst.pins(1'b0, 1'b1);
    pdm_far_model_inst.halt();
    modes(8'h0f);
    pdm_far_model_inst.irq(1'b1, 1'b1, 4'hf, 4'h0);
    pdm_far_model_inst.dma();
    repeat (10) @(posedge mclk_i);
    modes(8'h0f);
    pdm_far_model_inst.irq(1'b0, 1'b1, 4'h0, 4'h0);
    pdm_far_model_inst.pins(1'b1, 1'b1);
    wait_wake(2'h2, 2'h0);
    reg_wr(`PDM_STBY_CTRL_ADDR, 8'h80);
    pdm_far_model_inst.halt();
    modes(8'h0e);
    pdm_far_model_inst.cfg(1'b0, 1'b0);
    pdm_far_model_inst.pins(1'b0, 1'b1);
    wait_wake(2'h2, 2'h0);
    $display("test standby done");
    reg_wr(`PDM_STBY_CTRL_ADDR, 8'h00);
    pdm_far_model_inst.halt();
    modes(8'h08);
    pdm_far_model_inst.irq(1'b1, 1'b1, 4'h3, 4'h3);
    repeat (10) @(posedge mclk_i);
    modes(8'h08);
    pdm_far_model_inst.irq(1'b1, 1'b0, 4'h9, 4'h3);
    repeat (10) @(posedge mclk_i);
    modes(8'h08);
    pdm_far_model_inst.irq(1'b1, 1'b1, 4'h9, 4'h3);
    wait_wake(2'h0, 2'h0);
    pdm_far_model_inst.irq(1'b0, 1'b1, 4'h0, 4'h3);
    pdm_far_model_inst.halt();
    pdm_far_model_inst.dma();
    wait_wake(2'h1, 2'h0);
    pdm_far_model_inst.halt();
    pdm_far_model_inst.pins(1'b0, 1'b0);
    wait_wake(2'h3, 2'h2);
    pdm_far_model_inst.pins(1'b1, 1'b1);
    repeat (10) @(posedge mclk_i);
    pdm_far_model_inst.halt();
    pdm_far_model_inst.pins(1'b1, 1'b0);
    wait_wake(2'h3, 2'h1);
    pdm_far_model_inst.pins(1'b1, 1'b1);
    $display("test sleep done");
    final_report();
  end
endmodule
